// [pkg/tcc_pkg.sv]
// Constants, offsets and bit layout of the timer capture/compare and interrupt mask block.
package tcc_pkg;

    // ========================================
    // Bus geometry
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 8;
    localparam int          VALUE_W     = 16;
    localparam int          NUM_TIMERS  = 3;
    localparam int          NUM_SRC     = 4;
    localparam int          NUM_LINES   = NUM_TIMERS * NUM_SRC;

    // ========================================
    // Register offsets; the high byte of a 16-bit register sits at base plus HIGH_STEP.
    localparam logic [11:0] HIGH_STEP   = 12'h001;
    localparam logic [11:0] T1_MASK_OFS = 12'h06F;
    localparam logic [11:0] T3_MASK_OFS = 12'h071;
    localparam logic [11:0] T4_MASK_OFS = 12'h072;
    localparam logic [11:0] T1_FLAG_OFS = 12'h036;
    localparam logic [11:0] T3_FLAG_OFS = 12'h038;
    localparam logic [11:0] T4_FLAG_OFS = 12'h039;
    localparam logic [11:0] COUNT_OFS   = 12'h0A4;
    localparam logic [11:0] CAPTURE_OFS = 12'h0A6;
    localparam logic [11:0] CMP_A_OFS   = 12'h9A8;
    localparam logic [11:0] CMP_B_OFS   = 12'h0AA;

    // ========================================
    // Bit positions of the four sources inside mask and flag registers.
    localparam int          CAPTURE_BIT = 5;
    localparam int          MATCH_B_BIT = 2;
    localparam int          MATCH_A_BIT = 1;
    localparam int          OVERFL_BIT  = 0;

    // Index of each source inside the packed four-bit source vector.
    typedef enum logic [1:0] {
        SRC_OVERFLOW = 2'b00,
        SRC_MATCH_A  = 2'b01,
        SRC_MATCH_B  = 2'b10,
        SRC_CAPTURE  = 2'b11
    } tcc_src_type;

    // ========================================
    // Reset values
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [3:0]  SRC_RESET   = 4'h0;

    // Places a four-bit source vector at its register bit positions, other bits zero.
    function automatic logic [7:0] tcc_to_byte(input logic [3:0] src);
        logic [7:0] b;
        b = 8'h00;
        b[CAPTURE_BIT] = src[SRC_CAPTURE];
        b[MATCH_B_BIT] = src[SRC_MATCH_B];
        b[MATCH_A_BIT] = src[SRC_MATCH_A];
        b[OVERFL_BIT]  = src[SRC_OVERFLOW];
        return b;
    endfunction

    // Gathers the four implemented bits of a register byte.
    function automatic logic [3:0] tcc_from_byte(input logic [7:0] b);
        return {b[CAPTURE_BIT], b[MATCH_B_BIT], b[MATCH_A_BIT], b[OVERFL_BIT]};
    endfunction

endpackage

// [hdl/tcc_irq_gate.sv]
// Event flags and interrupt gating for all sources of the three timers.
`timescale 1ns/100ps
module tcc_irq_gate (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    // Events, clears and masks, one bit per source line
    input  wire logic [tcc_pkg::NUM_LINES-1:0] events,
    input  wire logic [tcc_pkg::NUM_LINES-1:0] clears,
    input  wire logic [tcc_pkg::NUM_LINES-1:0] masks,
    input  wire logic                          global_irq_enable,
    // Flags and requests
    output logic      [tcc_pkg::NUM_LINES-1:0] flags,
    output logic      [tcc_pkg::NUM_LINES-1:0] irq
);
    import tcc_pkg::*;

    // ========================================
    // Per-line flag and gate
    genvar i;
    generate
        for (i = 0; i < NUM_LINES; i++) begin : g_line
            logic flag;
            // An event in the clearing cycle keeps the flag set.
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    flag <= 1'b0;
                end else begin
                    flag <= events[i] | (flag & ~clears[i]);
                end
            end
            assign flags[i] = flag;
            assign irq[i] = flags[i] & masks[i] & global_irq_enable;
        end
    endgenerate

    // ========================================
    // Checks
    a_set_wins_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        (events != '0) |=> ((flags & $past(events)) == $past(events)))
        else $error("event lost against a clear");
    a_clear_drops_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        ((clears & ~events) != '0) |=> ((flags & $past(clears & ~events)) == '0))
        else $error("flag survived its clear");
    a_no_global_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
        !global_irq_enable |-> (irq == '0))
        else $error("interrupt raised without global enable");
endmodule

// [hdl/tcc_capture_compare.sv]
// Timer 4 capture and compare registers with the shared high-byte latch and timer masks.
`timescale 1ns/100ps
module tcc_capture_compare (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    // CPU data bus, byte wide
    input  wire logic [tcc_pkg::ADDR_W-1:0]    bus_addr,
    input  wire logic [tcc_pkg::DATA_W-1:0]    bus_wdata,
    input  wire logic                          bus_write,
    input  wire logic                          bus_read,
    output logic      [tcc_pkg::DATA_W-1:0]    bus_rdata,
    input  wire logic                          global_irq_enable,
    // Counter of timer 4
    input  wire logic [tcc_pkg::VALUE_W-1:0]   timer4_count,
    input  wire logic                          timer_tick,
    input  wire logic                          t4_overflow_event,
    output logic      [tcc_pkg::DATA_W-1:0]    high_byte_latch,
    // Capture source and mode
    input  wire logic                          capture_input_pin,
    input  wire logic                          capture_edge_rising,
    input  wire logic                          comparator_select,
    input  wire logic                          comparator_out,
    input  wire logic                          capture_is_top,
    output logic      [tcc_pkg::VALUE_W-1:0]   capture_top_value,
    // Waveform triggers
    output logic                               wave_out_a_trigger,
    output logic                               wave_out_b_trigger,
    // Events, vector acknowledges and requests of timers 1 and 3 and 4
    input  wire logic [tcc_pkg::NUM_SRC-1:0]   t1_events,
    input  wire logic [tcc_pkg::NUM_SRC-1:0]   t3_events,
    input  wire logic [tcc_pkg::NUM_SRC-1:0]   t1_vector_ack,
    input  wire logic [tcc_pkg::NUM_SRC-1:0]   t3_vector_ack,
    input  wire logic [tcc_pkg::NUM_SRC-1:0]   t4_vector_ack,
    output logic      [tcc_pkg::NUM_SRC-1:0]   t1_irq,
    output logic      [tcc_pkg::NUM_SRC-1:0]   t3_irq,
    output logic      [tcc_pkg::NUM_SRC-1:0]   t4_irq
);
    import tcc_pkg::*;

    // ========================================
    // Registers
    logic [VALUE_W-1:0]   timer4_capture_value;
    logic [VALUE_W-1:0]   timer4_compare_a_value;
    logic [VALUE_W-1:0]   timer4_compare_b_value;
    logic [NUM_LINES-1:0] mask_bits;
    logic [NUM_LINES-1:0] flag_bits;
    logic [NUM_LINES-1:0] irq_bits;
    logic                 source_prev;
    logic                 source_valid;
    logic                 block_pending;

    // ========================================
    // Address decode
    wire wr_cap_lo  = bus_write && (bus_addr == CAPTURE_OFS);
    wire wr_cap_hi  = bus_write && (bus_addr == CAPTURE_OFS + HIGH_STEP);
    wire wr_cma_lo  = bus_write && (bus_addr == CMP_A_OFS);
    wire wr_cma_hi  = bus_write && (bus_addr == CMP_A_OFS + HIGH_STEP);
    wire wr_cmb_lo  = bus_write && (bus_addr == CMP_B_OFS);
    wire wr_cmb_hi  = bus_write && (bus_addr == CMP_B_OFS + HIGH_STEP);
    wire wr_cnt_lo  = bus_write && (bus_addr == COUNT_OFS);
    wire wr_cnt_hi  = bus_write && (bus_addr == COUNT_OFS + HIGH_STEP);
    wire rd_cap_lo  = bus_read && (bus_addr == CAPTURE_OFS);
    wire rd_cnt_lo  = bus_read && (bus_addr == COUNT_OFS);
    wire wr_any_hi  = wr_cap_hi | wr_cma_hi | wr_cmb_hi | wr_cnt_hi;

    // Every high-byte write and every low-byte snapshot go through one latch.
    wire [DATA_W-1:0] next_high_byte_latch =
        wr_any_hi ? bus_wdata :
        rd_cap_lo ? timer4_capture_value[15:8] :
        rd_cnt_lo ? timer4_count[15:8] :
        high_byte_latch;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            high_byte_latch <= BYTE_RESET;
        end else begin
            high_byte_latch <= next_high_byte_latch;
        end
    end

    // ========================================
    // Input capture
    wire capture_source = comparator_select ? comparator_out : capture_input_pin;
    // The first sample after reset only primes the detector, so an idle-high pin makes no edge.
    wire rise_seen      = capture_source & ~source_prev;
    wire fall_seen      = ~capture_source & source_prev;
    wire capture_edge   = source_valid && (capture_edge_rising ? rise_seen : fall_seen);
    wire capture_event  = capture_edge && !capture_is_top;
    wire top_reached    = capture_is_top && timer_tick
                          && (timer4_count == timer4_capture_value);

    wire [VALUE_W-1:0] next_capture_value =
        capture_event ? timer4_count :
        wr_cap_lo     ? {high_byte_latch, bus_wdata} :
        timer4_capture_value;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            source_prev          <= 1'b0;
            source_valid         <= 1'b0;
            timer4_capture_value <= VALUE_RESET;
        end else begin
            source_prev          <= capture_source;
            source_valid         <= 1'b1;
            timer4_capture_value <= next_capture_value;
        end
    end

    assign capture_top_value = timer4_capture_value;

    // ========================================
    // Compare units
    wire eq_a    = (timer4_count == timer4_compare_a_value);
    wire eq_b    = (timer4_count == timer4_compare_b_value);
    wire match_a = timer_tick && eq_a && !block_pending;
    wire match_b = timer_tick && eq_b && !block_pending;

    // A counter write blocks the first timer clock that follows it.
    wire next_block_pending = wr_cnt_lo | (block_pending & ~timer_tick);

    wire [VALUE_W-1:0] next_compare_a =
        wr_cma_lo ? {high_byte_latch, bus_wdata} : timer4_compare_a_value;
    wire [VALUE_W-1:0] next_compare_b =
        wr_cmb_lo ? {high_byte_latch, bus_wdata} : timer4_compare_b_value;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timer4_compare_a_value <= VALUE_RESET;
            timer4_compare_b_value <= VALUE_RESET;
            block_pending          <= 1'b0;
            wave_out_a_trigger     <= 1'b0;
            wave_out_b_trigger     <= 1'b0;
        end else begin
            timer4_compare_a_value <= next_compare_a;
            timer4_compare_b_value <= next_compare_b;
            block_pending          <= next_block_pending;
            wave_out_a_trigger     <= match_a;
            wave_out_b_trigger     <= match_b;
        end
    end

    // ========================================
    // Masks, flags and interrupt requests
    localparam logic [NUM_TIMERS-1:0][11:0] MASK_OFS_LIST = {T4_MASK_OFS, T3_MASK_OFS,
                                                             T1_MASK_OFS};
    localparam logic [NUM_TIMERS-1:0][11:0] FLAG_OFS_LIST = {T4_FLAG_OFS, T3_FLAG_OFS,
                                                             T1_FLAG_OFS};

    wire [NUM_SRC-1:0] t4_events = {capture_event | top_reached, match_b, match_a,
                                    t4_overflow_event};
    wire [NUM_LINES-1:0] all_events = {t4_events, t3_events, t1_events};
    wire [NUM_LINES-1:0] all_acks   = {t4_vector_ack, t3_vector_ack, t1_vector_ack};
    wire [NUM_LINES-1:0] w1c_bits;
    wire [NUM_TIMERS-1:0][DATA_W-1:0] mask_bytes;
    wire [NUM_TIMERS-1:0][DATA_W-1:0] flag_bytes;
    wire [NUM_TIMERS-1:0] mask_hit;
    wire [NUM_TIMERS-1:0] flag_hit;

    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : g_timer
            wire mask_wr = bus_write && (bus_addr == MASK_OFS_LIST[t]);
            wire flag_wr = bus_write && (bus_addr == FLAG_OFS_LIST[t]);
            logic [NUM_SRC-1:0] enables;
            assign mask_bits[t*NUM_SRC +: NUM_SRC] = enables;
            assign mask_hit[t]   = (bus_addr == MASK_OFS_LIST[t]);
            assign flag_hit[t]   = (bus_addr == FLAG_OFS_LIST[t]);
            assign mask_bytes[t] = tcc_to_byte(mask_bits[t*NUM_SRC +: NUM_SRC]);
            assign flag_bytes[t] = tcc_to_byte(flag_bits[t*NUM_SRC +: NUM_SRC]);
            assign w1c_bits[t*NUM_SRC +: NUM_SRC] =
                flag_wr ? tcc_from_byte(bus_wdata) : SRC_RESET;
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    enables <= SRC_RESET;
                end else if (mask_wr) begin
                    // Bits 5, 2, 1 and 0 map to capture, B, A and overflow.
                    enables <= tcc_from_byte(bus_wdata);
                end
            end
        end
    endgenerate

    tcc_irq_gate u_gate (
        .ref_clk           (ref_clk),
        .resetn            (resetn),
        .events            (all_events),
        .clears            (w1c_bits | all_acks),
        .masks             (mask_bits),
        .global_irq_enable (global_irq_enable),
        .flags             (flag_bits),
        .irq               (irq_bits)
    );

    assign t1_irq = irq_bits[0 +: NUM_SRC];
    assign t3_irq = irq_bits[NUM_SRC +: NUM_SRC];
    assign t4_irq = irq_bits[2*NUM_SRC +: NUM_SRC];

    // ========================================
    // Read data
    wire [DATA_W-1:0] mask_rd = mask_hit[0] ? mask_bytes[0] :
                                mask_hit[1] ? mask_bytes[1] :
                                mask_hit[2] ? mask_bytes[2] : BYTE_RESET;
    wire [DATA_W-1:0] flag_rd = flag_hit[0] ? flag_bytes[0] :
                                flag_hit[1] ? flag_bytes[1] :
                                flag_hit[2] ? flag_bytes[2] : BYTE_RESET;
    wire [DATA_W-1:0] read_mux =
        (bus_addr == CAPTURE_OFS)             ? timer4_capture_value[7:0] :
        (bus_addr == CAPTURE_OFS + HIGH_STEP) ? high_byte_latch :
        (bus_addr == COUNT_OFS)               ? timer4_count[7:0] :
        (bus_addr == COUNT_OFS + HIGH_STEP)   ? high_byte_latch :
        (bus_addr == CMP_A_OFS)               ? timer4_compare_a_value[7:0] :
        (bus_addr == CMP_A_OFS + HIGH_STEP)   ? timer4_compare_a_value[15:8] :
        (bus_addr == CMP_B_OFS)               ? timer4_compare_b_value[7:0] :
        (bus_addr == CMP_B_OFS + HIGH_STEP)   ? timer4_compare_b_value[15:8] :
        (mask_hit != '0)                      ? mask_rd :
        flag_rd;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= BYTE_RESET;
        end else if (bus_read) begin
            bus_rdata <= read_mux;
        end
    end

    // ========================================
    // Checks
    a_capture_copy: assert property (@(posedge ref_clk) disable iff (!resetn)
        capture_event |=> (timer4_capture_value == $past(timer4_count)))
        else $error("capture did not copy the count");
    a_capture_off_top: assert property (@(posedge ref_clk) disable iff (!resetn)
        (capture_is_top && !wr_cap_lo) |=> $stable(timer4_capture_value))
        else $error("capture taken while used as top");
    a_read_snapshot: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_cap_lo |=> (high_byte_latch == $past(timer4_capture_value[15:8])))
        else $error("capture high byte not latched on low read");
    a_compare_commit: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_cma_lo |=> (timer4_compare_a_value == {$past(high_byte_latch), $past(bus_wdata)}))
        else $error("compare A not committed from latch");
    a_match_flag_next: assert property (@(posedge ref_clk) disable iff (!resetn)
        (timer_tick && eq_b && !block_pending)
        |=> (wave_out_b_trigger && flag_bits[2*NUM_SRC + SRC_MATCH_B]))
        else $error("compare B match not flagged next cycle");
    a_match_a_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        (timer_tick && eq_a && !block_pending)
        |=> (wave_out_a_trigger && flag_bits[2*NUM_SRC + SRC_MATCH_A]))
        else $error("compare A match not flagged next cycle");
    a_write_arms: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_cnt_lo |=> block_pending)
        else $error("counter write did not arm the match block");
    a_write_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
        (block_pending && timer_tick) |=> (!wave_out_a_trigger && !wave_out_b_trigger))
        else $error("match after counter write not suppressed");
    a_block_once: assert property (@(posedge ref_clk) disable iff (!resetn)
        (block_pending && timer_tick && !wr_cnt_lo) |=> !block_pending)
        else $error("match block outlived one timer clock");
    a_latch_write: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_any_hi |=> (high_byte_latch == $past(bus_wdata)))
        else $error("high byte write missed the shared latch");
    a_top_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        top_reached |=> flag_bits[2*NUM_SRC + SRC_CAPTURE])
        else $error("capture flag not set at top");
    a_mask_zero_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
        (bus_read && mask_hit != '0) |=> (bus_rdata[7:6] == 2'b00 && bus_rdata[4:3] == 2'b00))
        else $error("unimplemented mask bits read non-zero");
    a_capture_irq_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (flag_bits[2*NUM_SRC + SRC_CAPTURE] && global_irq_enable)
        |-> (t4_irq[SRC_CAPTURE] == mask_bits[2*NUM_SRC + SRC_CAPTURE]))
        else $error("capture interrupt not following its mask");
    a_match_b_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (flag_bits[2*NUM_SRC + SRC_MATCH_B] && global_irq_enable)
        |-> (t4_irq[SRC_MATCH_B] == mask_bits[2*NUM_SRC + SRC_MATCH_B]))
        else $error("compare B interrupt not following its mask");
    a_match_a_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (flag_bits[NUM_SRC + SRC_MATCH_A] && global_irq_enable)
        |-> (t3_irq[SRC_MATCH_A] == mask_bits[NUM_SRC + SRC_MATCH_A]))
        else $error("compare A interrupt not following its mask");
    a_overflow_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (flag_bits[SRC_OVERFLOW] && global_irq_enable)
        |-> (t1_irq[SRC_OVERFLOW] == mask_bits[SRC_OVERFLOW]))
        else $error("overflow interrupt not following its mask");
endmodule

// [tb/tcc_cpu_model.sv]
// CPU core model that reads and writes the byte-wide data bus.
`timescale 1ns/100ps
module tcc_cpu_model (
    // Clock and returned data
    input  wire logic        ref_clk,
    input  wire logic [7:0]  bus_rdata,
    // Request
    output logic      [11:0] bus_addr  = 12'hfff,
    output logic      [7:0]  bus_wdata = 8'h00,
    output logic             bus_write = 1'b0,
    output logic             bus_read  = 1'b0
);
    // A request holds through its taking edge; released address and data show the inverse value, both strobes drop low.
    task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge ref_clk);
        #1;
        {bus_addr, bus_wdata, bus_write, bus_read} = {a, d, w, ~w};
        @(posedge ref_clk);
        #1;
        q = bus_rdata;
        {bus_addr, bus_wdata, bus_write, bus_read} = {~a, ~d, 2'b00};
    endtask
endmodule

// [tb/timer16_capture_compare_irq_mask_tb_top.sv]
// Self-checking bench for timer 4 capture/compare and the timer interrupt masks.
`timescale 1ns/100ps
module timer16_capture_compare_irq_mask_tb_top;
    import tcc_pkg::*;
    // ========================================
    // Signals and reference model state
    logic        ref_clk = 1'b0, resetn = 1'b0, gie = 1'b0, tick = 1'b0;
    logic        ovf = 1'b0, pin = 1'b0, is_top = 1'b0;
    logic        rise = 1'b1, csel = 1'b0, cmp = 1'b0;
    logic [15:0] count = 16'h0000;
    logic [3:0]  ev1 = 4'h0, ev3 = 4'h0;
    logic [3:0]  ack [3] = '{default: 4'h0};
    logic [3:0]  mf [3] = '{default: 4'h0};
    logic [3:0]  irq [3];
    logic [3:0]  mm;
    logic [11:0] mofs [3] = '{T1_MASK_OFS, T3_MASK_OFS, T4_MASK_OFS};
    logic [11:0] fofs [3] = '{T1_FLAG_OFS, T3_FLAG_OFS, T4_FLAG_OFS};
    logic [11:0] bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, latch, q, m;
    logic        bus_write, bus_read, trig_a, trig_b;
    logic [15:0] top_value, va, vb, c;
    int          n_fail = 0, n_checks = 0, na, nb;

    always #2 ref_clk = ~ref_clk;
    tcc_cpu_model cpu (.ref_clk(ref_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read));
    tcc_capture_compare dut (.ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .global_irq_enable(gie), .timer4_count(count),
        .timer_tick(tick), .t4_overflow_event(ovf), .high_byte_latch(latch),
        .capture_input_pin(pin), .capture_edge_rising(rise), .comparator_select(csel),
        .comparator_out(cmp), .capture_is_top(is_top), .capture_top_value(top_value),
        .wave_out_a_trigger(trig_a), .wave_out_b_trigger(trig_b), .t1_events(ev1),
        .t3_events(ev3), .t1_vector_ack(ack[0]), .t3_vector_ack(ack[1]),
        .t4_vector_ack(ack[2]), .t1_irq(irq[0]), .t3_irq(irq[1]), .t4_irq(irq[2]));

    // ========================================
    // Shared tasks
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] d);
        cpu.access(1'b1, a, d, q);
    endtask
    task automatic rd(logic [11:0] a);
        cpu.access(1'b0, a, 8'h00, q);
    endtask
    task automatic wr16(logic [11:0] a, logic [15:0] v);
        wr(a + HIGH_STEP, v[15:8]);
        wr(a, v[7:0]);
    endtask
    task automatic chk16(string n, logic [11:0] a, logic [15:0] e);
        rd(a);
        chk(n, e[7:0], q);
        rd(a + HIGH_STEP);
        chk(n, e[15:8], q);
    endtask
    // Places the sources at bits 5, 2, 1 and 0 of a register byte.
    function automatic logic [7:0] reg_of(logic [3:0] s);
        return {2'b00, s[3], 2'b00, s[2], s[1], s[0]};
    endfunction
    // One timer tick, then counts trigger pulses over the following cycles.
    task automatic ticks();
        na = 0;
        nb = 0;
        @(posedge ref_clk);
        #1 tick = 1'b1;
        repeat (4) begin
            @(posedge ref_clk);
            #1 tick = 1'b0;
            na += (trig_a === 1'b1);
            nb += (trig_b === 1'b1);
        end
    endtask

    // ========================================
    // Main sequence
    initial begin
        void'($urandom(77725));
        repeat (4) @(posedge ref_clk);
        #1 resetn = 1'b1;
        for (int t = 0; t < 3; t++) begin
            rd(mofs[t]);
            chk("mask_reset", 8'h00, q);
            rd(fofs[t]);
            chk("flag_reset", 8'h00, q);
        end
        chk16("cmp_a_reset", CMP_A_OFS, 16'h0000);
        va = 16'($urandom);
        vb = va ^ 16'h5a5a;
        wr16(CMP_A_OFS, va);
        wr16(CMP_B_OFS, vb);
        chk16("cmp_a", CMP_A_OFS, va);
        chk16("cmp_b", CMP_B_OFS, vb);
        wr(CMP_B_OFS + HIGH_STEP, ~vb[15:8]);
        chk("latch", ~vb[15:8], latch);
        chk16("cmp_b_kept", CMP_B_OFS, vb);
        count = va;
        ticks();
        chk("match_a", 8'd1, 8'(na));
        chk("match_b_idle", 8'd0, 8'(nb));
        count = vb;
        ticks();
        chk("match_b", 8'd1, 8'(nb));
        mf[2] = 4'h6;
        rd(T4_FLAG_OFS);
        chk("t4_flags", reg_of(mf[2]), q);
        wr(COUNT_OFS, 8'h00);
        ticks();
        chk("blocked", 8'd0, 8'(nb));
        ticks();
        chk("unblocked", 8'd1, 8'(nb));
        c = 16'($urandom);
        count = c;
        pin = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 pin = 1'b0;
        mf[2][3] = 1'b1;
        chk16("capture", CAPTURE_OFS, c);
        chk("latch_cap", c[15:8], latch);
        chk("top_lo", c[7:0], top_value[7:0]);
        chk("top_hi", c[15:8], top_value[15:8]);
        chk16("count_read", COUNT_OFS, count);
        is_top = 1'b1;
        count = ~c;
        pin = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 pin = 1'b0;
        chk16("capture_held", CAPTURE_OFS, c);
        wr(T4_FLAG_OFS, 8'h20);
        count = c;
        ticks();
        rd(T4_FLAG_OFS);
        chk("top_flag", reg_of(mf[2]), q);
        is_top = 1'b0;
        // Falling edge of the comparator output as capture source.
        {rise, csel, count} = {1'b0, 1'b1, ~c};
        cmp = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 cmp = 1'b0;
        @(posedge ref_clk);
        #1 {rise, csel} = 2'b10;
        chk16("capture_fall", CAPTURE_OFS, ~c);
        {ev1, ev3, ovf} = {4'hf, 4'hf, 1'b1};
        @(posedge ref_clk);
        #1 {ev1, ev3, ovf} = {4'h0, 4'h0, 1'b0};
        mf = '{default: 4'hf};
        for (int t = 0; t < 3; t++) begin
            for (int r = 0; r < 2; r++) begin
                m = r ? ~m : 8'($urandom);
                wr(mofs[t], m);
                rd(mofs[t]);
                chk("mask", m & 8'h27, q);
                mm = {m[5], m[2], m[1], m[0]};
                for (int g = 0; g < 2; g++) begin
                    @(posedge ref_clk);
                    #1 gie = g[0];
                    #1 q = {4'h0, mf[t] & mm & {4{gie}}};
                    chk("irq", q, {4'h0, irq[t]});
                end
            end
            @(posedge ref_clk);
            #1 ack[t] = 4'h5;
            @(posedge ref_clk);
            #1 ack[t] = 4'h0;
            wr(fofs[t], 8'h22);
            rd(fofs[t]);
            chk("flag_clear", 8'h00, q);
            chk("irq_clear", 8'h00, {4'h0, irq[t]});
        end
        finish_test();
    end
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule
